// file: hdl/strap_config_and_powerdown_control.sv
// Strap sampling, power-down sequencing and link indicator of a single-pair PHY.
//
// The plain strobed port and the placing of the registers were decided locally.
`timescale 1ns/1ps
`include "strap_consts.svh"

// Notes on behaviour
// - Link indicator pin goes active whenever the link-up flag is set.
// - Indicator is active high after reset; a polarity bit makes it active low.
// - Indicator pin doubles as address strap bit 2, sampled before driving.
// - Reset held: everything off, pins tristated, registers unreachable.
// - Soft power-down: clock runs, line inputs ignored, link dropped.
// - Soft power-down: MAC outputs held low, registers still accessible.
// - Soft power-down entered by request bit, or after reset by strap.
// - A status bit reports that soft power-down has been reached.
// - Clearing the request leaves power-down and starts link bring-up.
// - Straps sampled right after any reset, then pins resume normal roles.
// - Sampled straps load register defaults at every reset.
// - Host writes may override strap-derived settings afterwards, except the MAC interface mode and a high level strapped off.
// - Floating straps give address 0, power-down on, slave, both levels, RMII.
// - In RMII the converter strap or enable bit selects converter mode.
// - Converter strap on fourth transmit data pin: 0 normal, 1 converter.
// - Indicator function codes 7 to 10 are refused in blink mode 2.
// - Power-down strap 0 means power-down after reset, 1 means active.
// - Three address straps select one of eight management addresses.
module strap_config_and_powerdown_control
	import strap_pkg::*;
(
	input wire logic sys_clk,
	input wire logic srst,
	input wire reg_addr_t reg_addr,
	input wire reg_data_t reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output reg_data_t reg_rdata,
	input wire logic [7:0] cfg_pins_in,
	input wire logic link_indicator_in,
	output logic link_indicator_out,
	output logic link_indicator_oe_n,
	input wire logic link_up_in,
	input wire logic [7:0] mac_out_core,
	output logic [7:0] mac_out_pins,
	output logic mac_pins_oe_n,
	output logic line_enable,
	output logic pll_enable,
	output logic link_restart,
	output logic chip_ready,
	output logic soft_powerdown_reached,
	output logic [2:0] mgmt_address,
	output logic [1:0] mac_if_mode,
	output logic master_pref,
	output logic tx_high_able,
	output logic converter_active,
	output ind_func_t indicator0_function_select,
	output ind_func_t indicator1_function_select,
	output logic [1:0] indicator_modes
);
	// ------------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------------
	function automatic logic ind_func_ok(input ind_func_t f, input logic m);
		ind_func_ok = !(m == `IND_MODE2 && f >= `IND_NOMODE2_LO && f <= `IND_NOMODE2_HI);
	endfunction : ind_func_ok

	logic [`STRAP_W-1:0] pins_sync;

	pin_sync #(.W(`STRAP_W)) u_pin_sync (
		.sys_clk(sys_clk),
		.srst(srst),
		.pins_in({cfg_pins_in, link_indicator_in}),
		.pins_sync(pins_sync)
	);

	// ------------------------------------------------------------------------
	// Sequencing and configuration state
	// ------------------------------------------------------------------------
	seq_state_e state_ff, nxt_state;
	logic [1:0] cnt_ff, nxt_cnt;
	logic [`STRAP_W-1:0] strap_ff, nxt_strap;
	logic pd_ff, nxt_pd;
	logic pol_ff, nxt_pol;
	logic cnv_ff, nxt_cnv;
	logic mst_ff, nxt_mst;
	logic txhi_ff, nxt_txhi;
	logic [2:0] addr_ff, nxt_addr;
	logic [1:0] macif_ff, nxt_macif;
	ind_func_t f0_ff, nxt_f0, f1_ff, nxt_f1;
	logic m0_ff, nxt_m0, m1_ff, nxt_m1;
	logic restart_ff, nxt_restart;
	logic run;
	logic latch;
	logic wr_ctrl;
	logic wr_ind;
	ind_func_t w_f0, w_f1;

	assign run = (state_ff == SEQ_RUN);
	assign latch = (state_ff == SEQ_SETTLE) && (cnt_ff == `CNT_ZERO);
	assign wr_ctrl = run && reg_wr && (reg_addr == `REG_CTRL);
	assign wr_ind = run && reg_wr && (reg_addr == `REG_IND);
	assign w_f0 = reg_wdata[`IND_F0_HI:`IND_F0_LO];
	assign w_f1 = reg_wdata[`IND_F1_HI:`IND_F1_LO];

	always_comb begin
		nxt_state = state_ff;
		nxt_cnt = cnt_ff;
		nxt_strap = strap_ff;
		nxt_pd = pd_ff;
		nxt_pol = pol_ff;
		nxt_cnv = cnv_ff;
		nxt_mst = mst_ff;
		nxt_txhi = txhi_ff;
		nxt_addr = addr_ff;
		nxt_macif = macif_ff;
		nxt_f0 = f0_ff;
		nxt_f1 = f1_ff;
		nxt_m0 = m0_ff;
		nxt_m1 = m1_ff;
		nxt_restart = 1'b0;
		case (state_ff)
			SEQ_HWPD: begin
				nxt_state = SEQ_SETTLE;
				nxt_cnt = `SETTLE_CYC;
			end
			SEQ_SETTLE: begin
				// The count covers the synchroniser so the latched levels are the pins' own.
				if (cnt_ff == `CNT_ZERO) begin
					nxt_state = SEQ_RUN;
					nxt_strap = pins_sync;
					nxt_pd = !pins_sync[`STRAP_SWPD];
					nxt_restart = pins_sync[`STRAP_SWPD];
					nxt_pol = `POL_ACT_HIGH;
					nxt_cnv = pins_sync[`STRAP_CNV];
					nxt_mst = pins_sync[`STRAP_MS];
					nxt_txhi = !pins_sync[`STRAP_TX];
					nxt_addr = {pins_sync[`STRAP_AD2], pins_sync[`STRAP_AD1],
						pins_sync[`STRAP_AD0]};
					nxt_macif = {pins_sync[`STRAP_MAC1], pins_sync[`STRAP_MAC0]};
					nxt_f0 = `IND0_DEF;
					nxt_f1 = `IND1_DEF;
					nxt_m0 = `IND_MODE1;
					nxt_m1 = `IND_MODE1;
				end else begin
					nxt_cnt = cnt_ff - `CNT_STEP;
				end
			end
			SEQ_RUN: begin
				if (wr_ctrl && reg_wdata[`CTRL_SFT_RST]) begin
					// Software reset re-runs the whole strap sequence.
					nxt_state = SEQ_SETTLE;
					nxt_cnt = `SETTLE_CYC;
				end else if (wr_ctrl) begin
					nxt_pd = reg_wdata[`CTRL_SFT_PD];
					nxt_restart = pd_ff && !reg_wdata[`CTRL_SFT_PD];
					nxt_pol = reg_wdata[`CTRL_POL];
					nxt_cnv = reg_wdata[`CTRL_CNV];
					nxt_mst = reg_wdata[`CTRL_MST];
					// High level stays off when strapped for the low level only.
					if (!strap_ff[`STRAP_TX]) begin
						nxt_txhi = reg_wdata[`CTRL_TXHI];
					end
				end
				if (run && reg_wr && (reg_addr == `REG_ADDR)) begin
					nxt_addr = reg_wdata[`ADDR_HI:`ADDR_LO];
				end
				if (wr_ind && ind_func_ok(w_f0, reg_wdata[`IND_M0])) begin
					nxt_f0 = w_f0;
					nxt_m0 = reg_wdata[`IND_M0];
				end
				if (wr_ind && ind_func_ok(w_f1, reg_wdata[`IND_M1])) begin
					nxt_f1 = w_f1;
					nxt_m1 = reg_wdata[`IND_M1];
				end
			end
			default: begin
				nxt_state = SEQ_HWPD;
			end
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			state_ff <= SEQ_HWPD;
			cnt_ff <= `CNT_ZERO;
			strap_ff <= '0;
			pd_ff <= 1'b1;
			pol_ff <= `POL_ACT_HIGH;
			cnv_ff <= 1'b0;
			mst_ff <= 1'b0;
			txhi_ff <= 1'b0;
			addr_ff <= '0;
			macif_ff <= `MACIF_RMII;
			f0_ff <= `IND0_DEF;
			f1_ff <= `IND1_DEF;
			m0_ff <= `IND_MODE1;
			m1_ff <= `IND_MODE1;
			restart_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			cnt_ff <= nxt_cnt;
			strap_ff <= nxt_strap;
			pd_ff <= nxt_pd;
			pol_ff <= nxt_pol;
			cnv_ff <= nxt_cnv;
			mst_ff <= nxt_mst;
			txhi_ff <= nxt_txhi;
			addr_ff <= nxt_addr;
			macif_ff <= nxt_macif;
			f0_ff <= nxt_f0;
			f1_ff <= nxt_f1;
			m0_ff <= nxt_m0;
			m1_ff <= nxt_m1;
			restart_ff <= nxt_restart;
		end
	end

	// ------------------------------------------------------------------------
	// Pin drivers and read data
	// ------------------------------------------------------------------------
	logic link_flag;
	logic ind_ff, nxt_ind;
	logic ind_oe_n_ff, nxt_ind_oe_n;
	logic [7:0] mac_ff, nxt_mac;
	logic mac_oe_n_ff, nxt_mac_oe_n;
	logic line_ff, nxt_line;
	logic pll_ff, nxt_pll;
	reg_data_t rdata_ff, nxt_rdata;
	reg_data_t rd_val;

	// An active link is dropped while powered down, whatever the core reports.
	assign link_flag = run && link_up_in && !pd_ff;

	always_comb begin
		rd_val = `RD_ZERO;
		case (reg_addr)
			`REG_CTRL: begin
				rd_val[`CTRL_SFT_PD] = pd_ff;
				rd_val[`CTRL_POL] = pol_ff;
				rd_val[`CTRL_CNV] = cnv_ff;
				rd_val[`CTRL_MST] = mst_ff;
				rd_val[`CTRL_TXHI] = txhi_ff;
			end
			`REG_STATUS: begin
				rd_val[`STAT_PD_RDY] = run && pd_ff;
				rd_val[`STAT_LINK] = link_flag;
				rd_val[`STAT_READY] = run;
				rd_val[`STAT_CNV] = converter_active;
			end
			`REG_STRAP: rd_val[`STRAP_W-1:0] = strap_ff;
			`REG_ADDR: rd_val[`ADDR_HI:`ADDR_LO] = addr_ff;
			`REG_IND: begin
				rd_val[`IND_F0_HI:`IND_F0_LO] = f0_ff;
				rd_val[`IND_F1_HI:`IND_F1_LO] = f1_ff;
				rd_val[`IND_M0] = m0_ff;
				rd_val[`IND_M1] = m1_ff;
			end
			default: rd_val = `RD_ZERO;
		endcase
		nxt_rdata = (reg_rd && run) ? rd_val : `RD_ZERO;
		nxt_ind = link_flag ^ pol_ff;
		nxt_ind_oe_n = !run;
		nxt_mac = (run && !pd_ff) ? mac_out_core : `MAC_LOW;
		nxt_mac_oe_n = !run;
		nxt_line = run && !pd_ff;
		nxt_pll = 1'b1;
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			rdata_ff <= `RD_ZERO;
			ind_ff <= 1'b0;
			ind_oe_n_ff <= 1'b1;
			mac_ff <= `MAC_LOW;
			mac_oe_n_ff <= 1'b1;
			line_ff <= 1'b0;
			pll_ff <= 1'b0;
		end else begin
			rdata_ff <= nxt_rdata;
			ind_ff <= nxt_ind;
			ind_oe_n_ff <= nxt_ind_oe_n;
			mac_ff <= nxt_mac;
			mac_oe_n_ff <= nxt_mac_oe_n;
			line_ff <= nxt_line;
			pll_ff <= nxt_pll;
		end
	end

	assign reg_rdata = rdata_ff;
	assign link_indicator_out = ind_ff;
	assign link_indicator_oe_n = ind_oe_n_ff;
	assign mac_out_pins = mac_ff;
	assign mac_pins_oe_n = mac_oe_n_ff;
	assign line_enable = line_ff;
	assign pll_enable = pll_ff;
	assign link_restart = restart_ff;
	assign chip_ready = run;
	assign soft_powerdown_reached = run && pd_ff;
	assign mgmt_address = addr_ff;
	assign mac_if_mode = macif_ff;
	assign master_pref = mst_ff;
	assign tx_high_able = txhi_ff;
	assign converter_active = cnv_ff && (macif_ff == `MACIF_RMII);
	assign indicator0_function_select = f0_ff;
	assign indicator1_function_select = f1_ff;
	assign indicator_modes = {m1_ff, m0_ff};

	// ------------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (srst);

	sequence s_pd_clear;
		run && pd_ff && wr_ctrl && !reg_wdata[`CTRL_SFT_PD] && !reg_wdata[`CTRL_SFT_RST];
	endsequence
	sequence s_restart_pulse;
		link_restart ##1 !link_restart;
	endsequence

	a_link_ind_level: assert property (
		run |=> (link_indicator_out == ($past(link_flag) ^ $past(pol_ff))))
		else $error("link indicator does not follow link flag");
	a_pol_after_reset: assert property (
		latch |=> (!pol_ff ##1 (link_indicator_out == $past(link_flag))))
		else $error("indicator not active high after reset");
	a_strap_tristate: assert property (
		!run |=> link_indicator_oe_n)
		else $error("indicator driven during strap sampling");
	a_hw_pd_off: assert property (disable iff (1'b0)
		srst |=> (!pll_enable && link_indicator_oe_n && mac_pins_oe_n && reg_rdata == `RD_ZERO))
		else $error("outputs active during hardware power-down");
	a_swpd_line_off: assert property (
		pd_ff |=> (!line_enable && (link_indicator_out == $past(pol_ff))))
		else $error("line active in soft power-down");
	a_swpd_mac_low: assert property (
		(run && pd_ff) |=> (mac_out_pins == `MAC_LOW))
		else $error("MAC outputs not low in soft power-down");
	a_swpd_reg_read: assert property (
		(run && pd_ff && reg_rd && reg_addr == `REG_CTRL) |=> reg_rdata[`CTRL_SFT_PD])
		else $error("register not readable in soft power-down");
	a_pd_from_strap: assert property (
		(latch && !pins_sync[`STRAP_SWPD]) |=> (pd_ff && soft_powerdown_reached))
		else $error("power-down strap not applied");
	a_pd_request_set: assert property (
		(wr_ctrl && reg_wdata[`CTRL_SFT_PD] && !reg_wdata[`CTRL_SFT_RST])
		|=> soft_powerdown_reached)
		else $error("power-down status not reported");
	a_pd_exit_restart: assert property (
		s_pd_clear |=> s_restart_pulse)
		else $error("no link bring-up after leaving power-down");
	a_strap_hold: assert property (
		run |=> $stable(strap_ff))
		else $error("straps changed outside a reset");
	a_addr_from_strap: assert property (
		latch |=> (mgmt_address == {$past(pins_sync[`STRAP_AD2]),
			$past(pins_sync[`STRAP_AD1]), $past(pins_sync[`STRAP_AD0])}))
		else $error("address straps not loaded");
	a_ind_mode2_refuse: assert property (
		(wr_ind && reg_wdata[`IND_M0] == `IND_MODE2 && w_f0 >= `IND_NOMODE2_LO
			&& w_f0 <= `IND_NOMODE2_HI) |=> $stable(indicator0_function_select))
		else $error("forbidden indicator code accepted in mode 2");
	a_cnv_rmii_only: assert property (
		latch |=> (converter_active == ($past(pins_sync[`STRAP_CNV])
			&& ($past(pins_sync[`STRAP_MAC1:`STRAP_MAC0]) == `MACIF_RMII))))
		else $error("converter mode not taken from strap in RMII");
endmodule : strap_config_and_powerdown_control

// file: hdl/strap_consts.svh
// Offsets, field positions, reset values and counts of the strap and power-down block.
`ifndef STRAP_CONSTS_SVH
`define STRAP_CONSTS_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define REG_CTRL 4'h0
`define REG_STATUS 4'h1
`define REG_STRAP 4'h2
`define REG_ADDR 4'h3
`define REG_IND 4'h4

// ----------------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------------
`define CTRL_SFT_PD 0
`define CTRL_SFT_RST 1
`define CTRL_POL 2
`define CTRL_CNV 3
`define CTRL_MST 4
`define CTRL_TXHI 5

// ----------------------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------------------
`define STAT_PD_RDY 0
`define STAT_LINK 1
`define STAT_READY 2
`define STAT_CNV 3

// ----------------------------------------------------------------------------
// Strap vector positions, after the synchroniser
// ----------------------------------------------------------------------------
`define STRAP_W 9
`define STRAP_AD2 0
`define STRAP_AD0 1
`define STRAP_AD1 2
`define STRAP_SWPD 3
`define STRAP_MS 4
`define STRAP_TX 5
`define STRAP_MAC0 6
`define STRAP_MAC1 7
`define STRAP_CNV 8

// ----------------------------------------------------------------------------
// Address and indicator register fields
// ----------------------------------------------------------------------------
`define ADDR_HI 2
`define ADDR_LO 0
`define IND_F0_HI 3
`define IND_F0_LO 0
`define IND_F1_HI 7
`define IND_F1_LO 4
`define IND_M0 8
`define IND_M1 9

// ----------------------------------------------------------------------------
// Values and counts
// ----------------------------------------------------------------------------
`define RD_ZERO 16'h0000
`define IND0_DEF 4'h1
`define IND1_DEF 4'h2
`define IND_MODE1 1'b0
`define IND_MODE2 1'b1
`define IND_NOMODE2_LO 4'h7
`define IND_NOMODE2_HI 4'hA
`define MACIF_RMII 2'h0
`define POL_ACT_HIGH 1'b0
`define SETTLE_CYC 2'h3
`define CNT_ZERO 2'h0
`define CNT_STEP 2'h1
`define MAC_LOW 8'h00

`endif

// file: hdl/strap_pkg.sv
// Types shared by the strap and power-down block.
package strap_pkg;
	typedef enum logic [1:0] {SEQ_HWPD, SEQ_SETTLE, SEQ_RUN} seq_state_e;
	typedef logic [15:0] reg_data_t;
	typedef logic [3:0] reg_addr_t;
	typedef logic [3:0] ind_func_t;
endpackage : strap_pkg

// file: hdl/pin_sync.sv
// Two-stage synchroniser for the strap and indicator pins.
`timescale 1ns/1ps
module pin_sync #(
	parameter int W = 9
) (
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic [W-1:0] pins_in,
	output logic [W-1:0] pins_sync
);
	logic [W-1:0] meta_ff;
	logic [W-1:0] sync_ff;
	logic [W-1:0] nxt_meta;
	logic [W-1:0] nxt_sync;

	always_comb begin
		nxt_meta = pins_in;
		nxt_sync = meta_ff;
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			meta_ff <= '0;
			sync_ff <= '0;
		end else begin
			meta_ff <= nxt_meta;
			sync_ff <= nxt_sync;
		end
	end

	assign pins_sync = sync_ff;
endmodule : pin_sync

// file: verif/strap_partner.sv
// Strap resistors and pin owner model on the far side of the strap block.
`timescale 1ns/1ps
module strap_partner (
	input wire logic [8:0] strap_val,
	input wire logic link_indicator_out,
	input wire logic link_indicator_oe_n,
	output logic [7:0] cfg_pins_in,
	output logic link_indicator_in
);
	// Resistor levels appear on the shared pins; bit 0 is the indicator pin.
	assign cfg_pins_in = strap_val[8:1];
	// The resistor wins only while the block leaves the pin undriven.
	assign link_indicator_in = link_indicator_oe_n ? strap_val[0] : link_indicator_out;
endmodule : strap_partner

// file: verif/strap_config_and_powerdown_control_tb.sv
// Self-checking bench of the strap sampling and power-down block.
`timescale 1ns/1ps
`include "strap_consts.svh"
module strap_config_and_powerdown_control_tb
	import strap_pkg::*;
;
	logic sys_clk = 1'b0;
	logic srst = 1'b1;
	reg_addr_t reg_addr = 4'h0;
	reg_data_t reg_wdata = 16'h0000;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	reg_data_t reg_rdata;
	logic [7:0] cfg_pins_in;
	logic link_indicator_in, link_indicator_out, link_indicator_oe_n;
	logic link_up_in = 1'b0;
	logic [7:0] mac_out_core = 8'h00;
	logic [7:0] mac_out_pins;
	logic mac_pins_oe_n, line_enable, pll_enable, link_restart, chip_ready;
	logic soft_powerdown_reached, master_pref, tx_high_able, converter_active;
	logic [2:0] mgmt_address;
	logic [1:0] mac_if_mode, indicator_modes;
	ind_func_t indicator0_function_select, indicator1_function_select;
	logic [8:0] strap_val = 9'h000;
	logic [15:0] rnd = 16'h747D;
	logic rd_d = 1'b0;
	int bad_count = 0;
	int checked = 0;
	reg_data_t exp_q[$];
	string name_q[$];
	reg_data_t prev;

	always #12.5 sys_clk = ~sys_clk;

	strap_partner partner (.strap_val(strap_val), .link_indicator_out(link_indicator_out),
		.link_indicator_oe_n(link_indicator_oe_n), .cfg_pins_in(cfg_pins_in),
		.link_indicator_in(link_indicator_in));

	strap_config_and_powerdown_control dut (.sys_clk(sys_clk), .srst(srst),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .cfg_pins_in(cfg_pins_in),
		.link_indicator_in(link_indicator_in), .link_indicator_out(link_indicator_out),
		.link_indicator_oe_n(link_indicator_oe_n), .link_up_in(link_up_in),
		.mac_out_core(mac_out_core), .mac_out_pins(mac_out_pins),
		.mac_pins_oe_n(mac_pins_oe_n), .line_enable(line_enable), .pll_enable(pll_enable),
		.link_restart(link_restart), .chip_ready(chip_ready),
		.soft_powerdown_reached(soft_powerdown_reached), .mgmt_address(mgmt_address),
		.mac_if_mode(mac_if_mode), .master_pref(master_pref), .tx_high_able(tx_high_able),
		.converter_active(converter_active),
		.indicator0_function_select(indicator0_function_select),
		.indicator1_function_select(indicator1_function_select),
		.indicator_modes(indicator_modes));

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic logic [15:0] lfsr(input logic [15:0] x);
		return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
	endfunction : lfsr

	task automatic final_report;
		$display("checks %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : final_report

	task automatic cmp(input string nm, input reg_data_t exp, input reg_data_t got);
		checked++;
		if (got !== exp) begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", nm, exp, got);
		end
	endtask : cmp

	task automatic wr(input reg_addr_t a, input reg_data_t d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
		#1;
	endtask : wr

	task automatic rd(input reg_addr_t a, input reg_data_t exp, input string nm);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		exp_q.push_back(exp);
		name_q.push_back(nm);
		@(posedge sys_clk);
		reg_rd <= 1'b0;
	endtask : rd

	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask : tick

	// A slow start would otherwise hang the run, so the wait is bounded.
	task automatic wait_ready;
		int n;
		for (n = 0; n < 40 && chip_ready !== 1'b1; n++) begin
			@(posedge sys_clk);
			#1;
		end
		if (chip_ready !== 1'b1) begin
			bad_count++;
			$display("mismatch chip_ready expected 1 seen %b", chip_ready);
			final_report();
		end
	endtask : wait_ready

	task automatic hw_reset;
		@(posedge sys_clk);
		srst <= 1'b1;
		tick(2);
		rd(`REG_STATUS, 16'h0000, "status_in_reset");
		#1;
		cmp("pins_in_reset", 16'h0006, {13'h0000, link_indicator_oe_n, mac_pins_oe_n, pll_enable});
		repeat (16) @(posedge sys_clk);
		srst <= 1'b0;
		wait_ready();
	endtask : hw_reset

	task automatic check_straps(input logic [8:0] s);
		logic cnv;
		cnv = s[8] & (s[7:6] == 2'h0);
		rd(`REG_STRAP, {7'h00, s}, "strap_reg");
		rd(`REG_ADDR, {13'h0000, s[0], s[2], s[1]}, "addr_reg");
		rd(`REG_CTRL, {10'h000, ~s[5], s[4], s[8], 2'h0, ~s[3]}, "ctrl_reg");
		rd(`REG_STATUS, {12'h000, cnv, 2'h2, ~s[3]}, "status_reg");
		rd(`REG_IND, 16'h0021, "ind_reg");
		tick(2);
		cmp("config_outs", {7'h00, s[0], s[2], s[1], s[7:6], s[4], ~s[5], cnv, ~s[3]},
			{7'h00, mgmt_address, mac_if_mode, master_pref, tx_high_able, converter_active,
			soft_powerdown_reached});
	endtask : check_straps

	// ------------------------------------------------------------
	// Read data monitor: one note is taken per completed read
	// ------------------------------------------------------------
	always @(posedge sys_clk) begin
		if (rd_d) begin
			if (exp_q.size() == 0) begin
				cmp("read_queue", 16'h0001, 16'h0000);
			end else begin
				cmp(name_q.pop_front(), exp_q.pop_front(), reg_rdata);
			end
		end
		rd_d = reg_rd;
	end

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		repeat (20) @(posedge sys_clk);
		srst <= 1'b0;
		wait_ready();
		for (int i = 0; i < 5; i++) begin
			rnd = lfsr(rnd);
			strap_val <= (i == 0) ? 9'h000 : rnd[8:0];
			tick(4);
			if (i % 2 == 0) begin
				hw_reset();
			end else begin
				wr(`REG_CTRL, 16'h0002);
				cmp("soft_reset_ready", 16'h0000, {15'h0000, chip_ready});
				wait_ready();
			end
			check_straps(strap_val);
			wr(`REG_CTRL, 16'h0020);
			rd(`REG_CTRL, {10'h000, ~strap_val[5], 5'h00}, "txhi_write");
			$display("test strap_load %0d done", i);
		end
		strap_val <= 9'h000;
		tick(4);
		wr(`REG_CTRL, 16'h0002);
		wait_ready();
		rnd = lfsr(rnd);
		mac_out_core <= rnd[7:0];
		link_up_in <= 1'b1;
		tick(3);
		cmp("soft_pd", 16'h0001, {6'h00, mac_out_pins, line_enable, pll_enable});
		cmp("pd_indicator", 16'h0000, {15'h0000, link_indicator_out});
		wr(`REG_CTRL, 16'h0000);
		cmp("pd_exit", 16'h0002, {14'h0000, link_restart, soft_powerdown_reached});
		tick(1);
		cmp("run", 16'h0001, {14'h0000, link_restart, line_enable});
		tick(1);
		cmp("mac_pass", {8'h00, mac_out_core}, {8'h00, mac_out_pins});
		cmp("link_on", 16'h0001, {14'h0000, link_indicator_oe_n, link_indicator_out});
		wr(`REG_CTRL, 16'h0004);
		tick(1);
		cmp("link_low_act", 16'h0000, {15'h0000, link_indicator_out});
		link_up_in <= 1'b0;
		tick(2);
		cmp("link_off_low_act", 16'h0001, {15'h0000, link_indicator_out});
		wr(`REG_CTRL, 16'h003D);
		rd(`REG_CTRL, 16'h003D, "ctrl_override");
		tick(2);
		cmp("override_outs", 16'h000F,
			{12'h000, master_pref, tx_high_able, converter_active, soft_powerdown_reached});
		cmp("pd_mac_low", 16'h0000, {8'h00, mac_out_pins});
		$display("test power_down done");
		prev = 16'h0143;
		wr(`REG_IND, prev);
		for (int c = 7; c <= 10; c++) begin
			wr(`REG_IND, {6'h00, 2'h3, c[3:0], c[3:0]});
			rd(`REG_IND, prev, "ind_refused");
			prev = {8'h00, c[3:0], c[3:0]};
			wr(`REG_IND, prev);
			rd(`REG_IND, prev, "ind_accepted");
		end
		tick(2);
		cmp("ind_outs", prev, {6'h00, indicator_modes, indicator1_function_select,
			indicator0_function_select});
		$display("test indicator_codes done");
		strap_val <= ~strap_val;
		tick(5);
		rd(`REG_STRAP, 16'h0000, "strap_held");
		rd(4'hF, 16'h0000, "unmapped");
		tick(3);
		$display("test strap_hold done");
		final_report();
	end
endmodule : strap_config_and_powerdown_control_tb
